// >>> hw/ddgc_top.sv
// Purpose: Peripheral-disable, serial FIFO mirror and pin one-zero config bank
// Assumes: APB slave at 25 MHz; activate bits and options come from the same clock
// Notes:   Zero-wait answer; read data is captured in the setup cycle
//
// Functional notes
// RULE1: Read-only mirror of serial two FIFO control
// RULE2: Clear disable bit leaves activate bit alone
// RULE3: Set disable bit forces function off
// RULE4: Disable register locked when gate cfg=01, pin high
// RULE5: Write-protect bit forces media write-protected
// RULE6: Protect output ORs four protect terms
// RULE7: Disable bits 2:1 read zero
// RULE8: Bit 3 disables floppy controller
// RULE9: Bit 4 disables MIDI serial interface
// RULE10: Bit 5 disables serial port two
// RULE11: Bit 6 disables serial port one
// RULE12: Bit 7 disables parallel port
// RULE13: Config bit 0 selects input direction
// RULE14: Config bit 1 inverts pin value
// RULE15: Config bit 2 routes pin to button
// RULE16: Config bit 7 selects open drain
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ddgc_params.svh"

module ddgc_top
	import ddgc_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic [7:0]  sp2_fifo_ctrl_i,
	input  wire logic [7:0]  gate_cfg_i,
	input  wire logic        gating_pin_four_three_i,
	input  wire logic [4:0]  func_activate_i,
	output logic      [4:0]  func_enable_o,
	input  wire logic        force_wp_i,
	input  wire logic        drive_select_zero_n_i,
	input  wire logic        drive_select_one_n_i,
	input  wire logic        write_protect_n_i,
	output logic             write_protect_n_o,
	input  wire logic        pin_one_zero_i,
	output logic             pin_one_zero_o,
	output logic             pin_one_zero_oe_o,
	output logic             game_port1_button1_o
);

	// ==========================================================
	// Declarations
	ddgc_pin_if pif ();

	logic [3:0]  meta_r;
	logic [3:0]  sync_r;
	logic [3:0]  meta_nxt;
	logic [3:0]  sync_nxt;

	ddgc_apb_e   st_r;
	ddgc_apb_e   st_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        perr_r;
	logic        perr_nxt;
	logic [7:0]  dis_r;
	logic [7:0]  dis_nxt;
	ddgc_pcfg_s  pcfg_r;
	ddgc_pcfg_s  pcfg_nxt;
	logic        pdat_r;
	logic        pdat_nxt;

	ddgc_func_t  en_r;
	ddgc_func_t  en_nxt;
	logic        wpn_r;
	logic        wpn_nxt;

	logic [7:0]  rd_val;
	logic        hit;
	logic        lock;
	logic        wr_go;
	logic        ds0_sel;
	logic        ds1_sel;
	logic        wp_pin;

	// ==========================================================
	// Pin inputs pass two flip-flops before any logic sees them
	always_comb begin
		meta_nxt = {gating_pin_four_three_i, write_protect_n_i,
			drive_select_one_n_i, drive_select_zero_n_i};
		sync_nxt = meta_r;
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= 4'hf;
			sync_r <= 4'hf;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign ds0_sel = !sync_r[0];
	assign ds1_sel = !sync_r[1];
	assign wp_pin  = !sync_r[2];

	// RULE4: lock follows gating config and pin level
	assign lock = (gate_cfg_i[`DDGC_GATE_HI:`DDGC_GATE_LO] == `DDGC_GATE_LOCK)
		&& sync_r[3];

	// ==========================================================
	// Read decode
	always_comb begin
		rd_val = 8'h00;
		hit    = 1'b1;
		case (paddr_i)
			// RULE1: mirror with reserved bits zero
			`DDGC_ADDR_MIRROR: begin
				rd_val = sp2_fifo_ctrl_i & `DDGC_MIRR_MASK;
			end
			// RULE7: reserved bits read zero
			`DDGC_ADDR_DIS: begin
				rd_val = dis_r & `DDGC_DIS_MASK;
			end
			`DDGC_ADDR_PCFG: begin
				rd_val = pcfg_r & `DDGC_PCFG_MASK;
			end
			`DDGC_ADDR_PDAT: begin
				rd_val = {7'h00, pif.in_val};
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// APB slave and registers
	assign wr_go = (st_r == DDGC_ST_ACCESS) && psel_i && penable_i && pwrite_i;

	always_comb begin
		st_nxt     = st_r;
		prdata_nxt = prdata_r;
		perr_nxt   = perr_r;
		dis_nxt    = dis_r;
		pcfg_nxt   = pcfg_r;
		pdat_nxt   = pdat_r;
		case (st_r)
			DDGC_ST_IDLE: begin
				if (psel_i && !penable_i) begin
					st_nxt     = DDGC_ST_ACCESS;
					prdata_nxt = pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_val};
					perr_nxt   = !hit;
				end
			end
			DDGC_ST_ACCESS: begin
				st_nxt = DDGC_ST_IDLE;
				if (wr_go) begin
					case (paddr_i)
						// RULE4: locked writes are dropped silently
						`DDGC_ADDR_DIS: begin
							if (!lock) begin
								dis_nxt = pwdata_i[7:0] & `DDGC_DIS_MASK;
							end
						end
						`DDGC_ADDR_PCFG: begin
							pcfg_nxt = ddgc_pcfg_s'(pwdata_i[7:0] & `DDGC_PCFG_MASK);
						end
						`DDGC_ADDR_PDAT: begin
							pdat_nxt = pwdata_i[0];
						end
						default: begin
						end
					endcase
				end
			end
			default: begin
				st_nxt = DDGC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			st_r     <= DDGC_ST_IDLE;
			prdata_r <= 32'h0000_0000;
			perr_r   <= 1'b0;
			dis_r    <= `DDGC_DIS_RST;
			pcfg_r   <= ddgc_pcfg_s'(`DDGC_PCFG_RST);
			pdat_r   <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			prdata_r <= prdata_nxt;
			perr_r   <= perr_nxt;
			dis_r    <= dis_nxt;
			pcfg_r   <= pcfg_nxt;
			pdat_r   <= pdat_nxt;
		end
	end

	assign pready_o  = (st_r == DDGC_ST_ACCESS);
	assign pslverr_o = (st_r == DDGC_ST_ACCESS) && perr_r;
	assign prdata_o  = prdata_r;

	// ==========================================================
	// Function enables and write-protect
	always_comb begin
		// RULE2: clear disable bit passes activate
		// RULE3: set disable bit forces off
		// RULE8: floppy controller on bit 3
		// RULE9: MIDI interface on bit 4
		// RULE10: serial two on bit 5
		// RULE11: serial one on bit 6
		// RULE12: parallel port on bit 7
		en_nxt = func_activate_i & ~dis_r[`DDGC_DIS_FN_HI:`DDGC_DIS_FN_LO];
		// RULE5: register bit forces protection
		// RULE6: OR of four protect terms
		wpn_nxt = !((ds0_sel && force_wp_i) || (ds1_sel && force_wp_i)
			|| wp_pin || dis_r[`DDGC_DIS_WP_BIT]);
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			en_r  <= 5'h00;
			wpn_r <= 1'b1;
		end else begin
			en_r  <= en_nxt;
			wpn_r <= wpn_nxt;
		end
	end

	assign func_enable_o     = en_r;
	assign write_protect_n_o = wpn_r;

	// ==========================================================
	// Pin one-zero
	assign pif.cfg     = pcfg_r;
	assign pif.out_val = pdat_r;

	ddgc_pin u_pin (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.pif      (pif.pin),
		.pad_i    (pin_one_zero_i),
		.pad_o    (pin_one_zero_o),
		.pad_oe_o (pin_one_zero_oe_o)
	);

	// RULE15: button fed from the pin logic
	assign game_port1_button1_o = pif.btn;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	sequence s_setup_rd(logic [11:0] a);
		(st_r == DDGC_ST_IDLE) && psel_i && !penable_i && !pwrite_i && paddr_i == a;
	endsequence

	sequence s_wr_dis;
		wr_go && paddr_i == `DDGC_ADDR_DIS;
	endsequence

	chk_mirror_read: assert property ( // RULE1
		s_setup_rd(`DDGC_ADDR_MIRROR) |=> pready_o && !pslverr_o
		&& prdata_o == {24'h00_0000, $past(sp2_fifo_ctrl_i) & `DDGC_MIRR_MASK})
		else $error("mirror read value wrong");

	chk_dis_rsv_zero: assert property ( // RULE7
		s_setup_rd(`DDGC_ADDR_DIS) |=> prdata_o[2:1] == 2'h0
		&& prdata_o[7:0] == ($past(dis_r) & `DDGC_DIS_MASK))
		else $error("disable reserved bits not zero");

	chk_dis_locked: assert property ( // RULE4
		s_wr_dis and lock |=> dis_r == $past(dis_r))
		else $error("locked disable register changed");

	chk_dis_open: assert property ( // RULE4
		s_wr_dis and !lock |=> dis_r == ($past(pwdata_i[7:0]) & `DDGC_DIS_MASK))
		else $error("disable register write lost");

	chk_func_force: assert property ( // RULE3 RULE8 RULE9 RULE10 RULE11 RULE12
		1'b1 |=> (func_enable_o & $past(dis_r[`DDGC_DIS_FN_HI:`DDGC_DIS_FN_LO])) == 5'h00)
		else $error("disabled function still enabled");

	chk_func_follow: assert property ( // RULE2
		1'b1 |=> func_enable_o == ($past(func_activate_i)
		& ~$past(dis_r[`DDGC_DIS_FN_HI:`DDGC_DIS_FN_LO])))
		else $error("function enable does not follow activate");

	chk_wp_bit: assert property ( // RULE5
		dis_r[`DDGC_DIS_WP_BIT] |=> !write_protect_n_o)
		else $error("write-protect bit ignored");

	chk_wp_or: assert property ( // RULE6
		1'b1 |=> write_protect_n_o == !$past((!sync_r[0] && force_wp_i)
		|| (!sync_r[1] && force_wp_i) || !sync_r[2] || dis_r[0]))
		else $error("write-protect combination wrong");

	chk_wp_path: assert property ( // RULE6
		(!write_protect_n_i && !dis_r[0]) [*3] |=> !write_protect_n_o)
		else $error("drive write-protect not passed");

	chk_pcfg_reset: assert property ( // RULE13
		$fell(rst_i) |-> pcfg_r.dir_in && !pin_one_zero_oe_o)
		else $error("pin not input after reset");

endmodule : ddgc_top

`default_nettype wire

// >>> include/ddgc_params.svh
// Purpose: Offsets, field positions, masks and reset values of the disable/pin bank
// Assumes: APB byte addresses are four times the register index
// Notes:   Definitions only
`ifndef DDGC_PARAMS_SVH
`define DDGC_PARAMS_SVH

// ==========================================================
// Register indices and byte addresses
`define DDGC_IDX_MIRROR  12'h021
`define DDGC_IDX_DIS     12'h022
`define DDGC_IDX_PCFG    12'h023
`define DDGC_IDX_PDAT    12'h030
`define DDGC_ADDR_MIRROR (`DDGC_IDX_MIRROR << 2)
`define DDGC_ADDR_DIS    (`DDGC_IDX_DIS << 2)
`define DDGC_ADDR_PCFG   (`DDGC_IDX_PCFG << 2)
`define DDGC_ADDR_PDAT   (`DDGC_IDX_PDAT << 2)

// ==========================================================
// Field layout and implemented-bit masks
`define DDGC_MIRR_MASK   8'hcf
`define DDGC_DIS_MASK    8'hf9
`define DDGC_PCFG_MASK   8'h87
`define DDGC_DIS_WP_BIT  0
`define DDGC_DIS_FN_LO   3
`define DDGC_DIS_FN_HI   7
`define DDGC_GATE_LO     2
`define DDGC_GATE_HI     3
`define DDGC_GATE_LOCK   2'h1

// ==========================================================
// Reset values, taken on standby-power reset
`define DDGC_DIS_RST     8'h00
`define DDGC_PCFG_RST    8'h01

`endif

// >>> include/ddgc_pkg.sv
// Purpose: Types shared by the disable/pin bank modules
// Assumes: Constants live in ddgc_params.svh
// Notes:   APB states are one-hot
`default_nettype none

package ddgc_pkg;

	typedef enum logic [1:0] {
		DDGC_ST_IDLE   = 2'b01,
		DDGC_ST_ACCESS = 2'b10
	} ddgc_apb_e;

	typedef struct packed {
		logic       od;
		logic [3:0] rsv;
		logic       alt;
		logic       pol;
		logic       dir_in;
	} ddgc_pcfg_s;

	typedef logic [4:0] ddgc_func_t;

endpackage : ddgc_pkg

`default_nettype wire

// >>> include/ddgc_pin_if.sv
// Purpose: Carries pin configuration and pin value between bank and pin logic
// Assumes: One clock domain
// Notes:   in_val is the pad value after polarity
`timescale 1ns/100ps
`default_nettype none

interface ddgc_pin_if;
	import ddgc_pkg::*;

	ddgc_pcfg_s cfg;
	logic       out_val;
	logic       in_val;
	logic       btn;

	modport ctrl (output cfg, output out_val, input in_val, input btn);
	modport pin  (input cfg, input out_val, output in_val, output btn);

endinterface : ddgc_pin_if

`default_nettype wire

// >>> hw/ddgc_pin.sv
// Purpose: Pad logic of general purpose pin one-zero
// Assumes: Pad input is asynchronous to clock_i
// Notes:   Pad drive and enable are registered, one cycle behind the config
`timescale 1ns/100ps
`default_nettype none
`include "ddgc_params.svh"

module ddgc_pin
	import ddgc_pkg::*;
(
	input  wire logic   clock_i,
	input  wire logic   rst_i,
	ddgc_pin_if.pin     pif,
	input  wire logic   pad_i,
	output logic        pad_o,
	output logic        pad_oe_o
);

	logic meta_r;
	logic sync_r;
	logic meta_nxt;
	logic sync_nxt;
	logic drv;
	logic pad_nxt;
	logic oe_nxt;

	// ==========================================================
	// Pad input capture
	always_comb begin
		meta_nxt = pad_i;
		sync_nxt = meta_r;
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	// RULE14: polarity between pad and register
	assign pif.in_val = sync_r ^ pif.cfg.pol;
	// RULE15: alternate use feeds the game button
	assign pif.btn    = pif.cfg.alt & pif.in_val;

	// ==========================================================
	// Pad drive
	always_comb begin
		drv = pif.out_val ^ pif.cfg.pol;
		// RULE13: input direction never drives
		oe_nxt = !pif.cfg.dir_in && !pif.cfg.alt;
		// RULE16: open drain only pulls low
		if (pif.cfg.od) begin
			oe_nxt  = oe_nxt && !drv;
			pad_nxt = 1'b0;
		end else begin
			pad_nxt = drv;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pad_o    <= 1'b0;
			pad_oe_o <= 1'b0;
		end else begin
			pad_o    <= pad_nxt;
			pad_oe_o <= oe_nxt;
		end
	end

	// ==========================================================
	// Checks
	chk_pin_dir_in: assert property (@(posedge clock_i) disable iff (rst_i) // RULE13
		pif.cfg.dir_in |=> !pad_oe_o)
		else $error("pin driven while configured as input");
	chk_pin_pol: assert property (@(posedge clock_i) disable iff (rst_i) // RULE14
		!$past(rst_i, 2) |-> pif.in_val == ($past(pad_i, 2) ^ pif.cfg.pol))
		else $error("pin value polarity wrong");
	chk_pin_alt_fn: assert property (@(posedge clock_i) disable iff (rst_i) // RULE15
		pif.cfg.alt |-> (pif.btn == pif.in_val) ##1 !pad_oe_o)
		else $error("alternate function routing wrong");
	chk_pin_od_low: assert property (@(posedge clock_i) disable iff (rst_i) // RULE16
		pif.cfg.od |=> (!pad_oe_o || !pad_o) && (pad_oe_o == ($past(oe_nxt))))
		else $error("open drain drove high");
	chk_pin_pp_drive: assert property (@(posedge clock_i) disable iff (rst_i) // RULE16
		(!pif.cfg.od && !pif.cfg.dir_in && !pif.cfg.alt)
		|=> pad_oe_o && pad_o == $past(pif.out_val ^ pif.cfg.pol))
		else $error("push-pull output not driven");

endmodule : ddgc_pin

`default_nettype wire

// >>> test/ddgc_top_tb.sv
// Purpose: Self-checking bench of the disable/pin bank through APB
// Assumes: Master waits for pready; derived outputs settle within five cycles
// Notes:   Derived outputs are looked at on the falling edge, where they are stable; APB answers on the rising edge
`timescale 1ns/100ps
`default_nettype none
`include "ddgc_params.svh"

module ddgc_top_tb
	import ddgc_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prd;
	logic        prdy;
	logic        perr;
	logic [7:0]  sp2 = 8'hff;
	logic [7:0]  gcfg = 8'h00;
	logic        gpin = 1'b0;
	logic [4:0]  act = 5'h1f;
	logic [4:0]  fen;
	logic        frc = 1'b0;
	logic        ds0_n = 1'b1;
	logic        ds1_n = 1'b1;
	logic        wpi_n = 1'b1;
	logic        wpo_n;
	logic        pad = 1'b1;
	logic        po;
	logic        poe;
	logic        btn;
	logic [31:0] d;
	logic        er;
	int          fail_count = 0;
	int          checks_done = 0;
	logic [5:0]  wp_tab [6] = '{6'b111001, 6'b011100, 6'b101100, 6'b011001, 6'b110000, 6'b111010};

	always #20 clk = ~clk;

	ddgc_top ddgc_top_i (.clock_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
		.pslverr_o(perr), .sp2_fifo_ctrl_i(sp2), .gate_cfg_i(gcfg),
		.gating_pin_four_three_i(gpin), .func_activate_i(act), .func_enable_o(fen),
		.force_wp_i(frc), .drive_select_zero_n_i(ds0_n), .drive_select_one_n_i(ds1_n),
		.write_protect_n_i(wpi_n), .write_protect_n_o(wpo_n), .pin_one_zero_i(pad),
		.pin_one_zero_o(po), .pin_one_zero_oe_o(poe), .game_port1_button1_o(btn));

	// ==========================================================
	// Bus and compare tasks
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwr  <= w;
		pa   <= a;
		pwd  <= wd;
		@(posedge clk);
		pen <= 1'b1;
		// Answer is taken at the rising edge that sees pready high; only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		d    = prd;
		er   = perr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, d);
	endtask : rdc

	task automatic wt();
		repeat (5) @(posedge clk);
		@(negedge clk);
	endtask : wt

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	initial begin
		repeat (4000) @(posedge clk);
		fail_count++;
		finish_test();
	end

	// ==========================================================
	// Test sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdc(`DDGC_ADDR_DIS, 32'h00, "dis reset");
		rdc(`DDGC_ADDR_PCFG, 32'h01, "pcfg reset");
		rdc(`DDGC_ADDR_MIRROR, 32'hcf, "mirror");
		apb(1'b1, `DDGC_ADDR_MIRROR, 32'h00);
		sp2 <= 8'h4a;
		rdc(`DDGC_ADDR_MIRROR, 32'h4a, "mirror ro");
		apb(1'b0, 12'h000, 32'h0);
		chk("unmapped err", 32'h1, 32'(er));
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, `DDGC_ADDR_DIS, 32'h08 << i);
			wt();
			chk("func off", 32'(5'h1f & ~(5'h01 << i)), 32'(fen));
		end
		apb(1'b1, `DDGC_ADDR_DIS, 32'hff);
		rdc(`DDGC_ADDR_DIS, 32'hf9, "dis rsv");
		act <= 5'h15;
		apb(1'b1, `DDGC_ADDR_DIS, 32'h00);
		wt();
		chk("func follow", 32'h15, 32'(fen));
		@(posedge clk);
		gcfg <= 8'h04;
		gpin <= 1'b1;
		wt();
		apb(1'b1, `DDGC_ADDR_DIS, 32'h80);
		rdc(`DDGC_ADDR_DIS, 32'h00, "dis locked");
		gpin <= 1'b0;
		wt();
		apb(1'b1, `DDGC_ADDR_DIS, 32'h80);
		rdc(`DDGC_ADDR_DIS, 32'h80, "dis pin low");
		gcfg <= 8'h0c;
		gpin <= 1'b1;
		wt();
		apb(1'b1, `DDGC_ADDR_DIS, 32'h40);
		rdc(`DDGC_ADDR_DIS, 32'h40, "dis cfg open");
		gcfg <= 8'h00;
		// Table columns: drive selects, protect pin, force, disable bit 0, expected
		foreach (wp_tab[k]) begin
			@(posedge clk);
			{ds0_n, ds1_n, wpi_n, frc} <= wp_tab[k][5:2];
			apb(1'b1, `DDGC_ADDR_DIS, 32'(wp_tab[k][1]));
			wt();
			chk("wp out", 32'(wp_tab[k][0]), 32'(wpo_n));
		end
		apb(1'b1, `DDGC_ADDR_PCFG, 32'h00);
		apb(1'b1, `DDGC_ADDR_PDAT, 32'h01);
		wt();
		chk("pin drive", 32'h3, {30'h0, po, poe});
		apb(1'b1, `DDGC_ADDR_PCFG, 32'h02);
		wt();
		chk("pin inv", 32'h1, {30'h0, po, poe});
		rdc(`DDGC_ADDR_PDAT, 32'h00, "pin read inv");
		apb(1'b1, `DDGC_ADDR_PCFG, 32'h80);
		wt();
		chk("od high", 32'h0, 32'(poe));
		apb(1'b1, `DDGC_ADDR_PDAT, 32'h00);
		wt();
		chk("od low", 32'h1, {30'h0, po, poe});
		apb(1'b1, `DDGC_ADDR_PCFG, 32'h01);
		wt();
		chk("pin input", 32'h0, {30'h0, poe, btn});
		apb(1'b1, `DDGC_ADDR_PCFG, 32'h05);
		wt();
		chk("button", 32'h1, {30'h0, poe, btn});
		@(posedge clk);
		pad <= 1'b0;
		wt();
		chk("button low", 32'h0, 32'(btn));
		apb(1'b1, `DDGC_ADDR_PCFG, 32'h07);
		wt();
		chk("button inv", 32'h1, 32'(btn));
		apb(1'b1, `DDGC_ADDR_PCFG, 32'hff);
		rdc(`DDGC_ADDR_PCFG, 32'h87, "pcfg rsv");
		finish_test();
	end

endmodule : ddgc_top_tb

`default_nettype wire
